/* File: design/ascm_clock_ctrl.sv */
`timescale 1ns/1ps
module ascm_clock_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic bclk_in,
  input wire logic frame_sync_in,
  output logic bclk_out,
  output logic bclk_oe,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  output logic pll_enable,
  output logic custom_clocking,
  output logic root_clock_from_ref,
  output logic reference_by_frame_ratio,
  output logic [15:0] reference_khz,
  output logic [11:0] reference_frame_ratio
);
  import ascm_pkg::*;

  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [7:0] src_sel;
  logic [15:0] acc;
  logic bclk_gen;
  logic [11:0] bit_idx;
  logic frame_gen;
  logic [3:0] measured_sample_rate;
  logic [3:0] measured_bits_per_frame;

  // ==========================================================
  // Field decode
  wire bus_role_select = cfg_a[ROLE_BIT];
  wire custom_mode = cfg_a[CUSTOM_BIT];
  wire automatic_pll_bypass = cfg_a[PLL_BYPASS_BIT];
  wire outgoing_clock_gate = cfg_a[GATE_BIT];
  wire rate_family_select = cfg_a[FAMILY_BIT];
  wire [2:0] reference_frequency_code = cfg_a[REF_CODE_LSB +: 3];
  wire [3:0] programmed_sample_rate = cfg_b[RATE_LSB +: 4];
  wire [3:0] programmed_bits_per_frame = cfg_b[RATIO_LSB +: 4];
  wire root_clock_source_select = src_sel[ROOT_SRC_BIT];
  wire reference_frequency_method = src_sel[REF_METHOD_BIT];
  wire [2:0] reference_ratio_code = src_sel[REF_RATIO_LSB +: 3];
  wire slave_auto = ~bus_role_select & ~custom_mode;

  // ==========================================================
  // Register port
  wire hit_a = reg_addr == ADDR_CFG_A;
  wire hit_b = reg_addr == ADDR_CFG_B;
  wire hit_src = reg_addr == ADDR_SRC;
  wire [7:0] read_mux = hit_a ? cfg_a :
                        hit_b ? cfg_b :
                        hit_src ? src_sel :
                        (reg_addr == ADDR_STATUS) ?
                          {measured_sample_rate, measured_bits_per_frame} : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_a <= RESET_CFG_A;
      cfg_b <= RESET_CFG_B;
      src_sel <= RESET_SRC;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_write && hit_a) begin
        cfg_a <= reg_wdata;
      end
      if (reg_write && hit_b) begin
        cfg_b <= reg_wdata;
      end
      if (reg_write && hit_src) begin
        src_sel <= reg_wdata;
      end
      if (reg_read) begin
        reg_rdata <= read_mux;
      end
    end
  end

  // ==========================================================
  // Clock tree controls
  assign custom_clocking = custom_mode;
  // Custom mode leaves PLL control to custom programming, so it is off here
  assign pll_enable = ~custom_mode & ~automatic_pll_bypass;
  assign root_clock_from_ref = slave_auto & automatic_pll_bypass &
                               root_clock_source_select;
  assign reference_by_frame_ratio = bus_role_select & reference_frequency_method;
  assign reference_khz = 16'(REF_KHZ[reference_frequency_code]);
  assign reference_frame_ratio = 12'(REF_RATIO[reference_ratio_code]);

  // ==========================================================
  // Master clock generator
  // Fractional accumulator: bclk averages fs*ratio with clk-rate jitter
  wire rate_ok = programmed_sample_rate < 4'(RATE_CODES);
  wire ratio_ok = programmed_bits_per_frame < 4'(RATIO_CODES);
  wire gen_run = bus_role_select & rate_ok & ratio_ok;
  wire [15:0] frame_period =
    ascm_rate_period(rate_family_select, programmed_sample_rate);
  wire [11:0] frame_bits = ascm_ratio_bits(programmed_bits_per_frame);
  wire [16:0] acc_sum = {1'b0, acc} + {4'h0, frame_bits, 1'b0};
  wire toggle = acc_sum >= {1'b0, frame_period};
  wire [16:0] acc_rem = acc_sum - {1'b0, frame_period};
  // Rates above clk/2 saturate; the remainder is dropped instead of wrapping
  wire [15:0] next_acc = !toggle ? acc_sum[15:0] :
                         (acc_rem >= {1'b0, frame_period}) ? 16'h0000 : acc_rem[15:0];
  wire bclk_fall = toggle & bclk_gen;
  // A ratio shortened mid-frame wraps at once instead of running up to 4096 bits
  wire last_bit = bit_idx >= frame_bits - 12'h001;
  wire [11:0] next_bit_idx = last_bit ? 12'h000 : bit_idx + 12'h001;

  always_ff @(posedge clk) begin
    if (reset || !gen_run) begin
      acc <= 16'h0000;
      bclk_gen <= 1'b0;
      bit_idx <= 12'h000;
      frame_gen <= 1'b0;
    end else begin
      acc <= next_acc;
      if (toggle) begin
        bclk_gen <= ~bclk_gen;
      end
      if (bclk_fall) begin
        bit_idx <= next_bit_idx;
        frame_gen <= next_bit_idx == 12'h000;
      end
    end
  end

  // ==========================================================
  // Pin drivers
  assign bclk_oe = bus_role_select;
  assign frame_sync_oe = bus_role_select;

  always_ff @(posedge clk) begin
    if (reset) begin
      bclk_out <= 1'b0;
      frame_sync_out <= 1'b0;
    end else begin
      bclk_out <= bus_role_select & ~outgoing_clock_gate & bclk_gen;
      frame_sync_out <= bus_role_select & ~outgoing_clock_gate & frame_gen;
    end
  end

  // In master role the monitor sees what this end puts on the bus
  wire bus_bclk = bus_role_select ? bclk_out : bclk_in;
  wire bus_frame_sync = bus_role_select ? frame_sync_out : frame_sync_in;

  ascm_monitor u_monitor (
    .clk(clk),
    .reset(reset),
    .bus_bclk(bus_bclk),
    .bus_frame_sync(bus_frame_sync),
    .measured_sample_rate(measured_sample_rate),
    .measured_bits_per_frame(measured_bits_per_frame)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  role_drive_a: assert property (
    bclk_oe == bus_role_select && frame_sync_oe == bus_role_select)
    else $error("clock enables disagree with role");
  slave_quiet_a: assert property (
    !bus_role_select ##1 !bus_role_select |-> !bclk_out && !frame_sync_out)
    else $error("slave drives clock outputs");
  gate_hold_a: assert property (
    outgoing_clock_gate && $past(outgoing_clock_gate) |-> !bclk_out && !frame_sync_out)
    else $error("gated clocks still toggle");
  custom_pll_a: assert property (custom_mode |-> !pll_enable)
    else $error("PLL enabled in custom mode");
  bypass_pll_a: assert property (!custom_mode && automatic_pll_bypass |-> !pll_enable)
    else $error("PLL enabled while bypassed");
  ref_reset_a: assert property ($past(reset) |-> reference_khz == 16'd13000)
    else $error("reference code reset wrong");
  root_sel_a: assert property (
    root_clock_from_ref |-> slave_auto && automatic_pll_bypass)
    else $error("root source outside slave bypass");
  bad_rate_a: assert property (programmed_sample_rate > 4'h8 |=> !bclk_gen)
    else $error("generator runs on reserved rate");
  frame_len_a: assert property (gen_run && bclk_fall && last_bit |=> frame_gen)
    else $error("frame sync missing after last bit");

  // ==========================================================
  // Register, clock tree and generator checks
  // Reads of the monitor byte return the status as it stood at the read edge
  status_read_a: assert property (
    reg_read && reg_addr == ADDR_STATUS |=>
    reg_rdata == $past({measured_sample_rate, measured_bits_per_frame}))
    else $error("status read returned wrong byte");
  cfg_store_a: assert property (
    reg_write && hit_b |=> cfg_b == $past(reg_wdata))
    else $error("configuration write lost");
  src_store_a: assert property (
    reg_write && hit_src |=> src_sel == $past(reg_wdata))
    else $error("source select write lost");
  // A refused configuration must stop the generator, not merely gate it
  gen_idle_a: assert property (
    !gen_run |=> !bclk_gen && !frame_gen && bit_idx == 12'h000)
    else $error("generator runs while not allowed");
  pll_auto_a: assert property (
    !custom_mode && !automatic_pll_bypass |-> pll_enable)
    else $error("PLL off in automatic mode");
  ref_method_a: assert property (
    bus_role_select && reference_frequency_method |-> reference_by_frame_ratio)
    else $error("frame ratio method not applied");
  frame_pulse_a: assert property (
    frame_gen && bclk_fall |=> !frame_gen)
    else $error("frame sync longer than one bit");
  family_period_a: assert property (
    rate_family_select && programmed_sample_rate == 4'h4 |->
    frame_period == 16'(CLK_HZ / FS44_HZ[4]))
    else $error("44.1 kHz family period wrong");

  cover_master_c: cover property (
    bus_role_select && !outgoing_clock_gate && $rose(frame_sync_out));
  cover_gated_c: cover property (bus_role_select && outgoing_clock_gate && gen_run);
  cover_slave_c: cover property (!bus_role_select && measured_sample_rate != 4'hf);

endmodule : ascm_clock_ctrl

/* File: design/ascm_pkg.sv */
package ascm_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CFG_A = 8'h13;
  localparam logic [7:0] ADDR_CFG_B = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h15;
  localparam logic [7:0] ADDR_SRC = 8'h16;
  localparam logic [7:0] RESET_CFG_A = 8'h02;
  localparam logic [7:0] RESET_CFG_B = 8'h48;
  localparam logic [7:0] RESET_STATUS = 8'hff;
  localparam logic [7:0] RESET_SRC = 8'h10;

  // ==========================================================
  // Field positions
  localparam int ROLE_BIT = 7;
  localparam int CUSTOM_BIT = 6;
  localparam int PLL_BYPASS_BIT = 5;
  localparam int GATE_BIT = 4;
  localparam int FAMILY_BIT = 3;
  localparam int REF_CODE_LSB = 0;
  localparam int RATE_LSB = 4;
  localparam int RATIO_LSB = 0;
  localparam int ROOT_SRC_BIT = 7;
  localparam int REF_METHOD_BIT = 6;
  localparam int REF_RATIO_LSB = 3;
  localparam logic [3:0] CODE_INVALID = 4'hf;
  localparam int RATE_CODES = 9;
  localparam int RATIO_CODES = 13;

  // ==========================================================
  // Timing and tables
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [15:0] PERIOD_SAT = 16'hffff;
  localparam int FS48_HZ [RATE_CODES] = '{8000, 16000, 24000, 32000, 48000, 96000,
                                        192000, 384000, 768000};
  localparam int FS44_HZ [RATE_CODES] = '{7350, 14700, 22050, 29400, 44100, 88200,
                                        176400, 352800, 705600};
  localparam int RATIO_BCLKS [RATIO_CODES] = '{16, 24, 32, 48, 64, 96, 128, 192, 256,
                                              384, 512, 1024, 2048};
  localparam int REF_KHZ [8] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
  localparam int REF_RATIO [8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};

  // Frame period in clk cycles for a rate code
  function automatic logic [15:0] ascm_rate_period(input logic fam44, input logic [3:0] code);
    int fs;
    fs = FS48_HZ[0];
    for (int i = 0; i < RATE_CODES; i++) begin
      if (code == 4'(i)) begin
        fs = fam44 ? FS44_HZ[i] : FS48_HZ[i];
      end
    end
    return 16'(CLK_HZ / fs);
  endfunction : ascm_rate_period

  // Tolerance of 1/64 keeps the two families apart
  function automatic logic [3:0] ascm_rate_lookup(input logic [15:0] period);
    logic [3:0] code;
    int nom;
    code = CODE_INVALID;
    nom = 0;
    for (int i = 0; i < RATE_CODES; i++) begin
      nom = CLK_HZ / FS48_HZ[i];
      if (int'(period) >= nom - (nom >> 6) && int'(period) <= nom + (nom >> 6)) begin
        code = 4'(i);
      end
      nom = CLK_HZ / FS44_HZ[i];
      if (int'(period) >= nom - (nom >> 6) && int'(period) <= nom + (nom >> 6)) begin
        code = 4'(i);
      end
    end
    return code;
  endfunction : ascm_rate_lookup

  function automatic logic [3:0] ascm_ratio_lookup(input logic [11:0] bits);
    logic [3:0] code;
    code = CODE_INVALID;
    for (int i = 0; i < RATIO_CODES; i++) begin
      if (int'(bits) == RATIO_BCLKS[i]) begin
        code = 4'(i);
      end
    end
    return code;
  endfunction : ascm_ratio_lookup

  function automatic logic [11:0] ascm_ratio_bits(input logic [3:0] code);
    logic [11:0] bits;
    bits = 12'h010;
    for (int i = 0; i < RATIO_CODES; i++) begin
      if (code == 4'(i)) begin
        bits = 12'(RATIO_BCLKS[i]);
      end
    end
    return bits;
  endfunction : ascm_ratio_bits

endpackage : ascm_pkg

/* File: design/ascm_monitor.sv */
`timescale 1ns/1ps
module ascm_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_bclk,
  input wire logic bus_frame_sync,
  output logic [3:0] measured_sample_rate,
  output logic [3:0] measured_bits_per_frame
);
  import ascm_pkg::*;

  logic prev_bclk;
  logic prev_frame_sync;
  logic armed;
  logic [15:0] cycle_cnt;
  logic [11:0] bit_cnt;

  wire bclk_rise = bus_bclk & ~prev_bclk;
  wire frame_start = bus_frame_sync & ~prev_frame_sync;
  wire timed_out = (cycle_cnt == PERIOD_SAT);
  wire [15:0] next_cycle_cnt = timed_out ? cycle_cnt : cycle_cnt + 16'h0001;
  wire [11:0] next_bit_cnt = (&bit_cnt) ? bit_cnt : bit_cnt + 12'h001;

  // ==========================================================
  // Frame measurement
  always_ff @(posedge clk) begin
    prev_bclk <= bus_bclk;
    prev_frame_sync <= bus_frame_sync;
    if (reset) begin
      armed <= 1'b0;
      cycle_cnt <= 16'h0000;
      bit_cnt <= 12'h000;
      measured_sample_rate <= RESET_STATUS[7:4];
      measured_bits_per_frame <= RESET_STATUS[3:0];
    end else if (frame_start) begin
      // First edge only opens a window; a partial frame is never reported
      armed <= 1'b1;
      cycle_cnt <= 16'h0001;
      bit_cnt <= bclk_rise ? 12'h001 : 12'h000;
      if (armed) begin
        measured_sample_rate <= ascm_rate_lookup(cycle_cnt);
        measured_bits_per_frame <= ascm_ratio_lookup(bit_cnt);
      end
    end else begin
      cycle_cnt <= next_cycle_cnt;
      if (bclk_rise) begin
        bit_cnt <= next_bit_cnt;
      end
      if (timed_out) begin
        // Stalled bus: report invalid rather than keep a stale code
        armed <= 1'b0;
        measured_sample_rate <= CODE_INVALID;
        measured_bits_per_frame <= CODE_INVALID;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  status_reset_a: assert property ($past(reset) |->
    measured_sample_rate == 4'hf && measured_bits_per_frame == 4'hf)
    else $error("status not all ones after reset");
  rate_code_a: assert property (
    measured_sample_rate <= 4'h8 || measured_sample_rate == 4'hf)
    else $error("reserved rate code reported");
  ratio_code_a: assert property (
    measured_bits_per_frame <= 4'hc || measured_bits_per_frame == 4'hf)
    else $error("reserved ratio code reported");
  stall_invalid_a: assert property (timed_out && !frame_start |=>
    measured_sample_rate == 4'hf && measured_bits_per_frame == 4'hf)
    else $error("stalled bus not reported invalid");
  ratio_match_a: assert property (
    frame_start && armed && bit_cnt == 12'h100 |=> measured_bits_per_frame == 4'h8)
    else $error("256 bits per frame not reported");

  cover_rate48_c: cover property (frame_start && armed ##1 measured_sample_rate == 4'h4);
  cover_timeout_c: cover property (timed_out);

endmodule : ascm_monitor

/* File: dv/ascm_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Host side of the serial audio bus: bit clock and frame sync source
module ascm_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic drive_en,
  input wire logic [7:0] half_period,
  input wire logic [11:0] bits_per_frame,
  output logic bclk,
  output logic frame_sync
);
  logic [7:0] half_cnt;
  logic [11:0] bit_idx;
  logic last_bit;
  assign last_bit = (bit_idx == bits_per_frame - 12'h001);
  always_ff @(posedge clk) begin
    if (reset) begin
      half_cnt <= 8'h00;
      bit_idx <= 12'h000;
      bclk <= 1'b0;
      frame_sync <= 1'b0;
    end else if (!drive_en) begin
      // Released lines float, so a changing pattern stands in for them
      half_cnt <= 8'h00;
      bit_idx <= 12'h000;
      bclk <= ~bclk;
      frame_sync <= ~frame_sync;
    end else if (half_cnt == half_period - 8'h01) begin
      half_cnt <= 8'h00;
      bclk <= ~bclk;
      if (bclk) begin
        bit_idx <= last_bit ? 12'h000 : bit_idx + 12'h001;
        frame_sync <= last_bit;
      end
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end
endmodule : ascm_host_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ==========================================================
// Bench top
module tb;
  import ascm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic bclk_out, bclk_oe, frame_sync_out, frame_sync_oe, pll_enable, custom_clocking;
  logic root_clock_from_ref, reference_by_frame_ratio;
  logic [15:0] reference_khz;
  logic [11:0] reference_frame_ratio;
  logic host_en = 1'b0;
  logic [7:0] host_half = 8'h08;
  logic [11:0] host_bits = 12'h010;
  logic host_bclk, host_frame_sync, rd_d, fs_d, seen;
  logic [7:0] exp_q[$];
  logic [7:0] e, a, b;
  logic [15:0] rnd = 16'haf39;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int frame_len = 0;
  int last_frame = 0;
  always #2.5 clk = ~clk;
  ascm_clock_ctrl u_ascm_clock_ctrl (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .bclk_in(host_bclk), .frame_sync_in(host_frame_sync),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_sync_out(frame_sync_out),
    .frame_sync_oe(frame_sync_oe), .pll_enable(pll_enable), .custom_clocking(custom_clocking),
    .root_clock_from_ref(root_clock_from_ref), .reference_by_frame_ratio(reference_by_frame_ratio),
    .reference_khz(reference_khz), .reference_frame_ratio(reference_frame_ratio));
  ascm_host_model u_ascm_host_model (.clk(clk), .reset(reset), .drive_en(host_en),
    .half_period(host_half), .bits_per_frame(host_bits), .bclk(host_bclk), .frame_sync(host_frame_sync));
  // ==========================================================
  // Watchers: read results, generated frame length, hang limit
  always @(posedge clk) begin
    rd_d <= reg_read;
    fs_d <= frame_sync_out;
    frame_len <= frame_len + 1;
    if (frame_sync_out && !fs_d) begin
      last_frame <= frame_len;
      frame_len <= 1;
    end
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
    @(posedge clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    exp_q.push_back(ex);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask : rd
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Slave role: host drives the bus, monitor must classify it
  task automatic slave_case(input logic [7:0] h, input logic [11:0] n, input logic [7:0] ex);
    host_half <= h;
    host_bits <= n;
    host_en <= 1'b1;
    repeat (8 * h * n + 20) @(posedge clk);
    rd(ADDR_STATUS, ex);
    host_en <= 1'b0;
    // Let the host see the release so its frame counter restarts
    @(posedge clk);
  endtask : slave_case
  // Master role: own clocks looped into the monitor
  task automatic master_case(input logic [7:0] c13, input logic [7:0] c14, input logic [7:0] ex);
    wr(ADDR_CFG_B, c14);
    wr(ADDR_CFG_A, c13);
    `CHK({bclk_oe, frame_sync_oe}, 2'b11)
    repeat (2200) @(posedge clk);
    rd(ADDR_STATUS, ex);
  endtask : master_case
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK({pll_enable, bclk_oe, reference_khz}, {2'b10, 16'h32c8})
    rd(ADDR_CFG_A, 8'h02);
    rd(ADDR_CFG_B, 8'h48);
    rd(ADDR_STATUS, 8'hff);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'hff);
    rd(ADDR_SRC, 8'h10);
    rd(8'h30, 8'h00);
    // Random configurations; status writes must be dropped
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr_next(rnd);
      a = rnd[7:0];
      b = rnd[15:8];
      wr(ADDR_CFG_A, a);
      wr(ADDR_SRC, b);
      wr(ADDR_STATUS, b);
      `CHK({bclk_oe, frame_sync_oe}, {a[7], a[7]})
      `CHK({custom_clocking, pll_enable}, {a[6], !a[6] && !a[5]})
      `CHK(reference_khz, 16'(REF_KHZ[a[2:0]]))
      `CHK(root_clock_from_ref, !a[7] && !a[6] && a[5] && b[7])
      `CHK(reference_by_frame_ratio, a[7] && b[6])
      `CHK(reference_frame_ratio, 12'(REF_RATIO[b[5:3]]))
      rd(ADDR_CFG_A, a);
      rd(ADDR_SRC, b);
    end
    wr(ADDR_CFG_A, 8'h00);
    slave_case(8'h08, 12'h010, 8'h80);
    slave_case(8'h08, 12'h020, 8'h72);
    slave_case(8'h06, 12'h018, 8'hf1);
    master_case(8'h80, 8'h80, 8'h80);
    `CHK(last_frame inside {[258:262]}, 1'b1)
    master_case(8'h80, 8'h72, 8'h72);
    master_case(8'h88, 8'h80, 8'h80);
    `CHK(last_frame inside {[281:285]}, 1'b1)
    // Gate and reserved rate code must both silence the outputs
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CFG_A, k == 0 ? 8'h90 : 8'h80);
      wr(ADDR_CFG_B, k == 0 ? 8'h80 : 8'h90);
      seen = 1'b0;
      // Two edges for the stopped generator to drain through the output flops
      repeat (2) @(posedge clk);
      repeat (600) begin
        @(posedge clk);
        seen = seen | bclk_out | frame_sync_out;
      end
      `CHK({seen, bclk_oe}, 2'b01)
    end
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : tb
